// ### cafc_filter_config.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1: fifo select bit routes to FIFO 0/1.
// RQ2: scale field at 6:5 or 2:1.
// RQ3: on bit at 4 or 0.
// RQ4: software clears on bit before pattern writes.
// RQ5: fifo select at bit 7 or 3.
// RQ6: upper half mode: 0 mask, 1 list.
// RQ7: lower half mode: 0 mask, 1 list.
// RQ8: upper mode register holds filters 7..4.
// RQ9: lower mode register holds filters 3..0.
// RQ10: identifier bit gives expected bus level.
// RQ11: mask bit 1 compares, 0 ignores.
// RQ12: eight pattern bytes, role from configuration.
// RQ13: same bit mapping in both roles.
// RQ14: control and mode registers reset to zero.
// RQ15: pattern bytes have no reset value.
// RQ16: configuration bits change only by writes.
// RQ17: fifo and scale change only in init.
// RQ18: inactive filter never matches nor routes.
module cafc_filter_config #(
  parameter int NUM_FILTERS = cafc_pkg::CAFC_NUM_FILTERS,
  parameter int PAT_BYTES   = cafc_pkg::CAFC_BYTES_PER_FLT
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire cafc_pkg::cafc_wb_req_t   wbReq,
  output logic                          wbAck,
  output logic      [31:0]              wbDatOut,
  input  wire logic                     initMode,
  input  wire logic [15:0]              candidateId,
  output cafc_pkg::cafc_filter_cfg_t    filterCfg [NUM_FILTERS],
  output logic      [NUM_FILTERS*PAT_BYTES*8-1:0] patternBytes,
  output logic      [NUM_FILTERS-1:0]   filterHit,
  output logic                          anyHit,
  output logic                          hitFifoSelect
);

  localparam int NUM_PAIRS = NUM_FILTERS / 2;
  localparam int DEPTH     = NUM_FILTERS * PAT_BYTES;
  localparam int IDX_W     = $clog2(DEPTH);

  logic [7:0]       pairCtrl [NUM_PAIRS];
  logic [7:0]       modeLower;
  logic [7:0]       modeUpper;
  logic             guardViolation;
  logic [7:0]       patReadData;
  logic [IDX_W-1:0] patIdx;
  logic             patWriteEn;
  logic             busActive;
  logic             busWrite;
  logic             lowLane;
  logic             inPattern;
  logic             patBlocked;
  logic [7:0]       writeByte;
  logic [7:0]       next_readByte;
  logic             ctrlHit;
  logic [1:0]       ctrlPairIdx;
  logic             guardSet;
  logic             regWrite;
  logic             ctrlSel;
  logic             modeLoSel;
  logic             modeUpSel;
  logic             statusSel;
  logic             next_anyHit;
  logic             next_hitFifoSelect;
  logic [NUM_FILTERS-1:0] next_filterHit;

  function automatic cafc_pkg::cafc_filter_cfg_t decodeCfg(input logic [7:0] ctrlByte,
                                                          input logic [7:0] modeByte,
                                                          input int         f);
    cafc_pkg::cafc_filter_cfg_t c;
    int                         slot;
    slot = f % 4;
    // RQ5 fifo bit position
    // RQ2 scale field position
    // RQ3 on bit position
    if (f % 2 == 1) begin
      c.fifoSelect  = ctrlByte[cafc_pkg::CAFC_UP_FIFO_BIT];
      c.scaleSelect = ctrlByte[cafc_pkg::CAFC_UP_SCALE_LSB +: 2];
      c.filterOn    = ctrlByte[cafc_pkg::CAFC_UP_ON_BIT];
    end else begin
      c.fifoSelect  = ctrlByte[cafc_pkg::CAFC_LO_FIFO_BIT];
      c.scaleSelect = ctrlByte[cafc_pkg::CAFC_LO_SCALE_LSB +: 2];
      c.filterOn    = ctrlByte[cafc_pkg::CAFC_LO_ON_BIT];
    end
    // RQ8 odd bit upper half
    // RQ9 even bit lower half
    c.upperHalfListMode = modeByte[2*slot+1];
    c.lowerHalfListMode = modeByte[2*slot];
    return c;
  endfunction

  // Compares one 16-bit half against the incoming identifier.
  function automatic logic halfMatch(input logic [15:0] cand,
                                     input logic [15:0] idPat,
                                     input logic [15:0] second,
                                     input logic        listMode);
    logic hit;
    // RQ10 expected bus levels
    // RQ11 mask selects compared bits
    // RQ13 uniform bit mapping
    if (listMode) begin
      hit = (cand == idPat) || (cand == second);
    end else begin
      hit = ((cand ^ idPat) & second) == 16'h0000;
    end
    return hit;
  endfunction

  // Gathers two adjacent pattern bytes of one filter as a little-endian word.
  function automatic logic [15:0] patWord(input logic [NUM_FILTERS*PAT_BYTES*8-1:0] all,
                                          input int                                 f,
                                          input int                                 k);
    logic [15:0] w;
    w = all[(f*PAT_BYTES + k)*8 +: 16];
    return w;
  endfunction

  // Merges a control byte write; outside init mode the fifo and scale bits keep their old value.
  function automatic logic [7:0] ctrlMerge(input logic [7:0] oldByte,
                                           input logic [7:0] newByte,
                                           input logic       unlocked);
    logic [7:0] m;
    if (unlocked) begin
      m = newByte;
    end else begin
      m = (oldByte & cafc_pkg::CAFC_INIT_ONLY_MASK) | (newByte & ~cafc_pkg::CAFC_INIT_ONLY_MASK);
    end
    return m;
  endfunction

  assign busActive = wbReq.cyc && wbReq.stb;
  assign busWrite  = busActive && wbReq.we && wbAck;
  assign lowLane   = wbReq.sel[0];
  assign writeByte = wbReq.dat[7:0];
  assign inPattern = (wbReq.adr >= cafc_pkg::CAFC_PATTERN_BASE) && (wbReq.adr <= cafc_pkg::CAFC_PATTERN_END);
  assign patIdx    = IDX_W'((wbReq.adr - cafc_pkg::CAFC_PATTERN_BASE) >> 2);
  assign ctrlHit   = wbReq.adr[11:4] == cafc_pkg::CAFC_CTRL_BASE[11:4];
  assign ctrlPairIdx = wbReq.adr[3:2];

  // Register selects shared by the write paths, the guard and the read mux.
  assign regWrite  = busWrite && lowLane;
  assign ctrlSel   = ctrlHit && (int'(ctrlPairIdx) < NUM_PAIRS);
  assign modeLoSel = wbReq.adr == cafc_pkg::CAFC_MODE_LOWER;
  assign modeUpSel = wbReq.adr == cafc_pkg::CAFC_MODE_UPPER;
  assign statusSel = wbReq.adr == cafc_pkg::CAFC_STATUS;

  // RQ4 pattern write guard
  assign patBlocked = filterCfg[patIdx / PAT_BYTES].filterOn;
  assign patWriteEn = busWrite && lowLane && inPattern && !patBlocked;

  // RQ12 eight bytes per filter
  // RQ15 storage without reset
  cafc_pattern_store #(
    .DEPTH (DEPTH),
    .WIDTH (8),
    .IDX_W (IDX_W)
  ) u_store (
    .clk       (clk),
    .writeEn   (patWriteEn),
    .writeIdx  (patIdx),
    .writeData (writeByte),
    .readIdx   (patIdx),
    .readData  (patReadData),
    .allBytes  (patternBytes)
  );

  // Wishbone acknowledge: one wait state, dropped after a single cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= busActive && !wbAck;
    end
  end

  // RQ14 zero after reset
  // RQ16 software writes only
  // RQ17 init mode protection
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < NUM_PAIRS; p++) begin
        pairCtrl[p] <= cafc_pkg::CAFC_CTRL_RESET;
      end
    end else if (regWrite && ctrlSel) begin
      pairCtrl[ctrlPairIdx] <= ctrlMerge(pairCtrl[ctrlPairIdx], writeByte, initMode);
    end
  end

  // RQ6 upper half mode storage
  // RQ7 lower half mode storage
  always_ff @(posedge clk) begin
    if (rst) begin
      modeLower <= cafc_pkg::CAFC_MODE_RESET;
      modeUpper <= cafc_pkg::CAFC_MODE_RESET;
    end else if (regWrite) begin
      if (modeLoSel) begin
        modeLower <= writeByte;
      end
      if (modeUpSel) begin
        modeUpper <= writeByte;
      end
    end
  end

  // Sticky flag for writes refused by the guards; a new refusal beats the clear.
  always_comb begin
    guardSet = 1'b0;
    if (regWrite) begin
      if (inPattern && patBlocked) begin
        guardSet = 1'b1;
      end
      if (ctrlSel && ctrlMerge(pairCtrl[ctrlPairIdx], writeByte, initMode) != writeByte) begin
        guardSet = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      guardViolation <= 1'b0;
    end else if (guardSet) begin
      guardViolation <= 1'b1;
    end else if (regWrite && statusSel && writeByte[cafc_pkg::CAFC_ST_GUARD_BIT]) begin
      guardViolation <= 1'b0;
    end
  end

  always_comb begin
    for (int f = 0; f < NUM_FILTERS; f++) begin
      filterCfg[f] = decodeCfg(pairCtrl[f/2], (f >= 4) ? modeUpper : modeLower, f);
    end
  end

  always_comb begin
    next_readByte = 8'h00;
    if (ctrlSel) begin
      next_readByte = pairCtrl[ctrlPairIdx];
    end else if (modeLoSel) begin
      next_readByte = modeLower;
    end else if (modeUpSel) begin
      next_readByte = modeUpper;
    end else if (statusSel) begin
      next_readByte[cafc_pkg::CAFC_ST_INIT_BIT]  = initMode;
      next_readByte[cafc_pkg::CAFC_ST_GUARD_BIT] = guardViolation;
    end else if (inPattern) begin
      next_readByte = patReadData;
    end
  end

  // Read data is captured as the acknowledge rises and held through it.
  always_ff @(posedge clk) begin
    if (rst) begin
      wbDatOut <= 32'h0000_0000;
    end else if (busActive && !wbAck && !wbReq.we) begin
      wbDatOut <= {24'h00_0000, next_readByte};
    end
  end

  // The lower half holds identifier in bytes 0..1 and mask or second identifier in bytes 2..3; the upper half uses bytes 4..5 and 6..7.
  always_comb begin
    next_filterHit     = '0;
    next_hitFifoSelect = 1'b0;
    for (int f = NUM_FILTERS - 1; f >= 0; f--) begin
      // RQ18 inactive filter excluded
      next_filterHit[f] = filterCfg[f].filterOn
                          && (halfMatch(candidateId, patWord(patternBytes, f, 0), patWord(patternBytes, f, 2),
                                        filterCfg[f].lowerHalfListMode)
                              || halfMatch(candidateId, patWord(patternBytes, f, 4),
                                           patWord(patternBytes, f, 6), filterCfg[f].upperHalfListMode));
      // RQ1 lowest hit filter routes
      if (next_filterHit[f]) begin
        next_hitFifoSelect = filterCfg[f].fifoSelect;
      end
    end
    next_anyHit = |next_filterHit;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filterHit     <= '0;
      anyHit        <= 1'b0;
      hitFifoSelect <= 1'b0;
    end else begin
      filterHit     <= next_filterHit;
      anyHit        <= next_anyHit;
      hitFifoSelect <= next_hitFifoSelect;
    end
  end

endmodule // cafc_filter_config

`default_nettype wire

// ### cafc_pkg.sv
package cafc_pkg;

  localparam int CAFC_NUM_FILTERS   = 8;
  localparam int CAFC_BYTES_PER_FLT = 8;
  localparam int CAFC_ADR_W         = 12;

  // Word-aligned byte addresses of the register map.
  localparam logic [11:0] CAFC_CTRL_BASE    = 12'h000;
  localparam logic [11:0] CAFC_MODE_LOWER   = 12'h010;
  localparam logic [11:0] CAFC_MODE_UPPER   = 12'h014;
  localparam logic [11:0] CAFC_STATUS       = 12'h018;
  localparam logic [11:0] CAFC_PATTERN_BASE = 12'h100;
  localparam logic [11:0] CAFC_PATTERN_END  = 12'h1FC;

  // Field positions inside a filter pair control byte.
  localparam int CAFC_UP_FIFO_BIT  = 7;
  localparam int CAFC_UP_SCALE_LSB = 5;
  localparam int CAFC_UP_ON_BIT    = 4;
  localparam int CAFC_LO_FIFO_BIT  = 3;
  localparam int CAFC_LO_SCALE_LSB = 1;
  localparam int CAFC_LO_ON_BIT    = 0;

  // Bits of a control byte that only change in initialization mode.
  localparam logic [7:0] CAFC_INIT_ONLY_MASK = 8'hEE;

  localparam int CAFC_ST_INIT_BIT  = 0;
  localparam int CAFC_ST_GUARD_BIT = 1;

  localparam logic [7:0] CAFC_CTRL_RESET = 8'h00;
  localparam logic [7:0] CAFC_MODE_RESET = 8'h00;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cafc_wb_req_t;

  typedef struct packed {
    logic       fifoSelect;
    logic [1:0] scaleSelect;
    logic       filterOn;
    logic       upperHalfListMode;
    logic       lowerHalfListMode;
  } cafc_filter_cfg_t;

endpackage

// ### cafc_pattern_store.sv
`timescale 1ns/1ps
`default_nettype none

// Byte-wide pattern storage; contents are left undefined until written.
module cafc_pattern_store #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 8,
  parameter int IDX_W = $clog2(DEPTH)
) (
  input  wire logic                   clk,
  input  wire logic                   writeEn,
  input  wire logic [IDX_W-1:0]       writeIdx,
  input  wire logic [WIDTH-1:0]       writeData,
  input  wire logic [IDX_W-1:0]       readIdx,
  output logic      [WIDTH-1:0]       readData,
  output logic      [DEPTH*WIDTH-1:0] allBytes
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (writeEn) begin
      mem[writeIdx] <= writeData;
    end
  end

  assign readData = mem[readIdx];

  always_comb begin
    allBytes = '0;
    for (int i = 0; i < DEPTH; i++) begin
      allBytes[i*WIDTH +: WIDTH] = mem[i];
    end
  end

endmodule // cafc_pattern_store

`default_nettype wire

// ### cafc_filter_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cafc_filter_config_chk (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire cafc_pkg::cafc_wb_req_t     wbReq,
  input wire logic                       wbAck,
  input wire logic [31:0]                wbDatOut,
  input wire logic                       initMode,
  input wire cafc_pkg::cafc_filter_cfg_t filterCfg [8],
  input wire logic [7:0]                 filterHit,
  input wire logic                       anyHit,
  input wire logic                       hitFifoSelect
);
  logic [47:0] cfgFlat;
  logic [23:0] lockFlat;
  logic [7:0]  onVec;
  always_comb begin
    for (int f = 0; f < 8; f++) begin
      cfgFlat[6*f +: 6] = filterCfg[f];
      lockFlat[3*f +: 3] = {filterCfg[f].fifoSelect, filterCfg[f].scaleSelect};
      onVec[f] = filterCfg[f].filterOn;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_ACK_NEXT: assert property ($rose(wbReq.cyc && wbReq.stb) |=> wbAck)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  AST_RD_BYTE: assert property (wbAck |-> wbDatOut[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_CFG_RESET: assert property ($fell(rst) |-> cfgFlat == 48'h0 && !anyHit)
    else $error("configuration not zero after reset");
  AST_CFG_WRITE_ONLY: assert property (!(wbAck && wbReq.we) |=> $stable(cfgFlat))
    else $error("configuration changed without a write");
  AST_INIT_LOCK: assert property (!initMode |=> $stable(lockFlat))
    else $error("fifo or scale changed outside init mode");
  AST_ANY_OR: assert property (anyHit == (|filterHit))
    else $error("any hit differs from filter hits");
  AST_OFF_NOHIT: assert property (1'b1 |=> (filterHit & ~$past(onVec)) == 8'h00)
    else $error("inactive filter reported a hit");
  AST_FIFO0: assert property (filterHit[0] |-> hitFifoSelect == $past(cfgFlat[5]))
    else $error("hit fifo differs from filter 0 assignment");
  AST_NOHIT_FIFO: assert property (!anyHit |-> !hitFifoSelect)
    else $error("fifo select set without a hit");
  cover property (wbAck && wbReq.we);
  cover property (anyHit && hitFifoSelect);
  cover property (!initMode && wbAck && wbReq.we);
endmodule // cafc_filter_config_chk
`default_nettype wire

// ### cafc_filter_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cafc_filter_config_tb;
  logic                       clk, rst, initMode, wbAck, anyHit, hitFifoSelect;
  cafc_pkg::cafc_wb_req_t     wbReq;
  logic [31:0]                wbDatOut, rd;
  logic [15:0]                candidateId, cand;
  cafc_pkg::cafc_filter_cfg_t filterCfg [8];
  logic [511:0]               patternBytes;
  logic [7:0]                 filterHit, modeLo, modeUp, b, ctrl [4], pat [64];
  int                         fail_count, n_checks, f, k, seed = 30;
  cafc_filter_config dut (.clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .initMode(initMode), .candidateId(candidateId), .filterCfg(filterCfg), .patternBytes(patternBytes),
    .filterHit(filterHit), .anyHit(anyHit), .hitFifoSelect(hitFifoSelect));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
    int n = 0;
    @(posedge clk);
    wbReq <= '{1'b1, 1'b1, we, a, s, {24'h000000, d}};
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    rd = wbDatOut;
    wbReq <= '0;
  endtask
  function automatic logic [5:0] cfgExp(input int x);
    logic [7:0] c, m;
    c = ctrl[x/2] >> (4*(x%2));
    m = (x < 4 ? modeLo : modeUp) >> (2*(x%4));
    return {c[3:0], m[1:0]};
  endfunction
  function automatic logic [9:0] hitExp(input logic [15:0] c);
    logic [7:0]  h;
    logic [5:0]  e;
    logic [15:0] id, sec;
    logic        fs;
    h = 8'h00;
    fs = 1'b0;
    for (int x = 7; x >= 0; x--) begin
      e = cfgExp(x);
      for (int j = 0; j < 8; j += 4) begin
        id = {pat[8*x+j+1], pat[8*x+j]};
        sec = {pat[8*x+j+3], pat[8*x+j+2]};
        if (e[2] && (e[j/4] ? (c == id || c == sec) : ((c ^ id) & sec) == 16'h0000)) begin
          h[x] = 1'b1;
          fs = e[5];
        end
      end
    end
    return {fs, |h, h};
  endfunction
  initial begin
    rst = 1'b1;
    initMode = 1'b1;
    wbReq = '0;
    candidateId = 16'h0000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 12'(4*i), 8'h00);
      chk(rd, (i == 6) ? 48'h1 : 48'h0);
    end
    modeLo = 8'($random(seed));
    modeUp = 8'($random(seed));
    bus(1'b1, 12'h010, modeLo);
    bus(1'b1, 12'h014, modeUp);
    for (int i = 0; i < 4; i++) begin
      ctrl[i] = 8'($random(seed)) & 8'hEE;
      bus(1'b1, 12'(4*i), ctrl[i]);
    end
    for (int i = 0; i < 64; i++) begin
      pat[i] = 8'($random(seed));
      bus(1'b1, 12'h100 + 12'(4*i), pat[i]);
    end
    // The last pattern write lands on the edge the task returns on.
    @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      chk(patternBytes[8*i +: 8], pat[i]);
    end
    bus(1'b0, 12'h13C, 8'h00);
    chk(rd, pat[15]);
    bus(1'b0, 12'h010, 8'h00);
    chk(rd, modeLo);
    bus(1'b0, 12'h014, 8'h00);
    chk(rd, modeUp);
    bus(1'b1, 12'h010, ~modeLo, 4'hE);
    bus(1'b0, 12'h010, 8'h00);
    chk(rd, modeLo);
    for (int x = 0; x < 8; x++) chk(filterCfg[x], cfgExp(x));
    initMode <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed)) | 8'h01;
      bus(1'b1, 12'(4*i), b);
      ctrl[i] = (ctrl[i] & 8'hEE) | (b & 8'h11);
      bus(1'b0, 12'(4*i), 8'h00);
      chk(rd, ctrl[i]);
    end
    for (int t = 0; t < 200; t++) begin
      f = {$random(seed)} % 8;
      k = 4 * ({$random(seed)} % 2);
      cand = {pat[8*f+k+1], pat[8*f+k]};
      if (t % 3 == 1) cand = cand ^ (16'($random(seed)) & ~{pat[8*f+k+3], pat[8*f+k+2]});
      if (t % 3 == 2) cand = 16'($random(seed));
      @(posedge clk);
      candidateId <= cand;
      @(posedge clk);
      #1;
      chk({hitFifoSelect, anyHit, filterHit}, hitExp(cand));
    end
    bus(1'b1, 12'h100, ~pat[0]);
    bus(1'b0, 12'h100, 8'h00);
    chk(rd, pat[0]);
    bus(1'b0, 12'h018, 8'h00);
    chk(rd, 48'h2);
    bus(1'b1, 12'h018, 8'h02);
    bus(1'b0, 12'h018, 8'h00);
    chk(rd, 48'h0);
    bus(1'b1, 12'h0F0, 8'hFF);
    bus(1'b0, 12'h0F0, 8'h00);
    chk(rd, 48'h0);
    // A reset in mid-run must clear the configuration again.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int x = 0; x < 8; x++) chk(filterCfg[x], 48'h0);
    chk({hitFifoSelect, anyHit, filterHit}, 48'h0);
    bus(1'b0, 12'h00C, 8'h00);
    chk(rd, 48'h0);
    bus(1'b0, 12'h014, 8'h00);
    chk(rd, 48'h0);
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule // cafc_filter_config_tb
bind cafc_filter_config cafc_filter_config_chk chk (.clk(clk), .rst(rst), .wbReq(wbReq), .wbAck(wbAck),
  .wbDatOut(wbDatOut), .initMode(initMode), .filterCfg(filterCfg), .filterHit(filterHit),
  .anyHit(anyHit), .hitFifoSelect(hitFifoSelect));
`default_nettype wire
